/* File: src/cam_defines.svh */
// Offsets, field positions, reset values and bus codes of the check activity monitor
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define CAM_ADDR_W          8
`define CAM_OFS_FLAGS       8'h00
`define CAM_OFS_CHAN_EN     8'h04
`define CAM_OFS_IRQ_STATUS  8'h08
`define CAM_OFS_IRQ_MASK    8'h0C

// ****************************************************************
// Field layout of the flag register
// ****************************************************************
`define CAM_CORE0_MSB       31
`define CAM_CORE1_MSB       23
`define CAM_CORE2_MSB       15
`define CAM_CORE3_MSB       7
`define CAM_CHANS           8
`define CAM_CORES           4

// Implemented sequencer cores, one bit per core, bit 0 is core 0
`define CAM_CORE_IMPL       4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define CAM_FLAGS_RESET     32'h0000_0000
`define CAM_CHAN_EN_RESET   32'hFFFF_FFFF
`define CAM_IRQ_STAT_RESET  4'h0
`define CAM_IRQ_MASK_RESET  4'h0

// ****************************************************************
// AXI response codes
// ****************************************************************
`define CAM_RESP_OKAY       2'h0
`define CAM_RESP_SLVERR     2'h2

`endif

/* File: src/cam_pkg.sv */
// Types shared by the check activity monitor files
package cam_pkg;

  typedef logic [7:0]  cam_chan_t;
  typedef logic [31:0] cam_word_t;
  typedef logic [3:0]  cam_core_t;
  typedef logic [1:0]  cam_resp_t;

endpackage : cam_pkg

/* File: src/cam_core_flags.sv */
// Eight sticky check activity flags of one sequencer core
`timescale 1ns/1ps
module cam_core_flags #(
  parameter bit IMPL = 1'b1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  input  wire cam_pkg::cam_chan_t check_in,
  input  wire cam_pkg::cam_chan_t chan_en_in,
  input  wire cam_pkg::cam_chan_t clear_in,
  output cam_pkg::cam_chan_t    flags_out,
  output logic                  new_out
);

  cam_pkg::cam_chan_t flags_reg;
  cam_pkg::cam_chan_t flags_next;
  cam_pkg::cam_chan_t check_fld;

  // Channel 0 sits in the top bit of the field
  always_comb begin
    check_fld = 8'h00;
    for (int i = 0; i < 8; i++) begin
      check_fld[7 - i] = check_in[i];
    end
  end

  // Set wins over a clear in the same cycle; unused or absent channels hold zero
  assign flags_next = {8{IMPL}} & chan_en_in & (check_fld | (flags_reg & ~clear_in));

  // A flag that goes from clear to set is a new event
  assign new_out = |(flags_next & ~flags_reg);

  // Flag storage
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_out = flags_reg;

endmodule : cam_core_flags

/* File: src/cam_top.sv */
// Check activity monitor: sticky flags for four sequencer cores behind AXI4-Lite
//
// Summary of operation
// - Core 0 owns bits 31..24, channel 0 top
// - Core 1 owns bits 23..16, channel 0 top
// - Core 2 owns bits 15..8, channel 0 top
// - Core 3 owns bits 7..0, channel 0 top
// - Writing one clears a flag; zero keeps
// - Reading flags never changes them
// - Absent cores and unused channels read zero
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cam_defines.svh"
module cam_top (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_b_in,
  // Check events, bit i is channel i, one-cycle pulse or level
  input  wire cam_pkg::cam_chan_t       sequencer_core_0_check_in,
  input  wire cam_pkg::cam_chan_t       sequencer_core_1_check_in,
  input  wire cam_pkg::cam_chan_t       sequencer_core_2_check_in,
  input  wire cam_pkg::cam_chan_t       sequencer_core_3_check_in,
  // AXI4-Lite write address
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [`CAM_ADDR_W-1:0]   s_axi_awaddr_in,
  input  wire logic [2:0]               s_axi_awprot_in,
  // AXI4-Lite write data
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  input  wire cam_pkg::cam_word_t       s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  output cam_pkg::cam_resp_t            s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  input  wire logic [`CAM_ADDR_W-1:0]   s_axi_araddr_in,
  input  wire logic [2:0]               s_axi_arprot_in,
  // AXI4-Lite read data
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  output cam_pkg::cam_word_t            s_axi_rdata_out,
  output cam_pkg::cam_resp_t            s_axi_rresp_out,
  // Level interrupt
  output logic                          irq_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Write channel holding registers
  logic                     aw_hold_reg;
  logic [`CAM_ADDR_W-1:0]   aw_addr_reg;
  logic                     w_hold_reg;
  cam_pkg::cam_word_t       w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     bvalid_reg;
  cam_pkg::cam_resp_t       bresp_reg;
  // Read channel registers
  logic                     rvalid_reg;
  cam_pkg::cam_word_t       rdata_reg;
  cam_pkg::cam_resp_t       rresp_reg;
  // Software registers
  cam_pkg::cam_word_t       chan_en_reg;
  cam_pkg::cam_word_t       chan_en_next;
  cam_pkg::cam_core_t       irq_stat_reg;
  cam_pkg::cam_core_t       irq_stat_next;
  cam_pkg::cam_core_t       irq_mask_reg;
  cam_pkg::cam_core_t       irq_mask_next;
  // Handshake and decode wires
  logic                     aw_take;
  logic                     w_take;
  logic                     ar_take;
  logic                     wr_fire;
  logic                     wr_sel_flags;
  logic                     wr_sel_chan_en;
  logic                     wr_sel_irq_stat;
  logic                     wr_sel_irq_mask;
  logic                     wr_hit;
  logic                     rd_sel_flags;
  logic                     rd_sel_chan_en;
  logic                     rd_sel_irq_stat;
  logic                     rd_sel_irq_mask;
  logic                     rd_hit;
  logic                     rd_clr_irq;
  cam_pkg::cam_word_t       wr_mask;
  cam_pkg::cam_word_t       flag_clear;
  cam_pkg::cam_word_t       flags_all;
  cam_pkg::cam_word_t       rd_word;
  cam_pkg::cam_core_t       core_new;

  // ****************************************************************
  // Named constants
  // ****************************************************************
  // Macro literals cannot be bit-selected, so they are given a width here
  localparam logic [`CAM_ADDR_W-1:0] OFS_FLAGS      = `CAM_OFS_FLAGS;
  localparam logic [`CAM_ADDR_W-1:0] OFS_CHAN_EN    = `CAM_OFS_CHAN_EN;
  localparam logic [`CAM_ADDR_W-1:0] OFS_IRQ_STATUS = `CAM_OFS_IRQ_STATUS;
  localparam logic [`CAM_ADDR_W-1:0] OFS_IRQ_MASK   = `CAM_OFS_IRQ_MASK;
  localparam logic [`CAM_CORES-1:0]  CORE_IMPL      = `CAM_CORE_IMPL;

  // ****************************************************************
  // Write address and data acceptance
  // ****************************************************************
  // Each channel is taken once and held until the response is sent
  assign s_axi_awready_out = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_out  = ~w_hold_reg & ~bvalid_reg;
  assign aw_take           = s_axi_awvalid_in & s_axi_awready_out;
  assign w_take            = s_axi_wvalid_in & s_axi_wready_out;

  // The write acts once both halves are held
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;

  // Address holding register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_take) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  // Data holding register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_strb_reg <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Word decode ignores the two byte bits
  assign wr_sel_flags    = aw_addr_reg[`CAM_ADDR_W-1:2] == OFS_FLAGS[`CAM_ADDR_W-1:2];
  assign wr_sel_chan_en  = aw_addr_reg[`CAM_ADDR_W-1:2] == OFS_CHAN_EN[`CAM_ADDR_W-1:2];
  assign wr_sel_irq_stat = aw_addr_reg[`CAM_ADDR_W-1:2] == OFS_IRQ_STATUS[`CAM_ADDR_W-1:2];
  assign wr_sel_irq_mask = aw_addr_reg[`CAM_ADDR_W-1:2] == OFS_IRQ_MASK[`CAM_ADDR_W-1:2];
  assign wr_hit          = wr_sel_flags | wr_sel_chan_en | wr_sel_irq_stat | wr_sel_irq_mask;

  // Byte strobes widened to a bit mask
  assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Ones written to the flag word clear those flags only
  assign flag_clear = (wr_fire & wr_sel_flags) ? (w_data_reg & wr_mask) : 32'h0000_0000;

  // Channel enable and interrupt mask take the written bytes
  assign chan_en_next  = (wr_fire & wr_sel_chan_en) ?
                         ((chan_en_reg & ~wr_mask) | (w_data_reg & wr_mask)) : chan_en_reg;
  assign irq_mask_next = (wr_fire & wr_sel_irq_mask & w_strb_reg[0]) ?
                         w_data_reg[`CAM_CORES-1:0] : irq_mask_reg;

  // ****************************************************************
  // Write response
  // ****************************************************************
  // Unmapped addresses are answered with a slave error and change nothing
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `CAM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `CAM_RESP_OKAY : `CAM_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out  = bresp_reg;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Channel enable and interrupt mask storage
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chan_en_reg  <= `CAM_CHAN_EN_RESET;
      irq_mask_reg <= `CAM_IRQ_MASK_RESET;
    end else begin
      chan_en_reg  <= chan_en_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ****************************************************************
  // Activity flag groups
  // ****************************************************************
  // Sequencer core 0 flags
  cam_core_flags #(
    .IMPL (CORE_IMPL[0])
  ) u_core0 (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .check_in   (sequencer_core_0_check_in),
    .chan_en_in (chan_en_reg[`CAM_CORE0_MSB -: `CAM_CHANS]),
    .clear_in   (flag_clear[`CAM_CORE0_MSB -: `CAM_CHANS]),
    .flags_out  (flags_all[`CAM_CORE0_MSB -: `CAM_CHANS]),
    .new_out    (core_new[0])
  );

  // Sequencer core 1 flags
  cam_core_flags #(
    .IMPL (CORE_IMPL[1])
  ) u_core1 (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .check_in   (sequencer_core_1_check_in),
    .chan_en_in (chan_en_reg[`CAM_CORE1_MSB -: `CAM_CHANS]),
    .clear_in   (flag_clear[`CAM_CORE1_MSB -: `CAM_CHANS]),
    .flags_out  (flags_all[`CAM_CORE1_MSB -: `CAM_CHANS]),
    .new_out    (core_new[1])
  );

  // Sequencer core 2 flags
  cam_core_flags #(
    .IMPL (CORE_IMPL[2])
  ) u_core2 (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .check_in   (sequencer_core_2_check_in),
    .chan_en_in (chan_en_reg[`CAM_CORE2_MSB -: `CAM_CHANS]),
    .clear_in   (flag_clear[`CAM_CORE2_MSB -: `CAM_CHANS]),
    .flags_out  (flags_all[`CAM_CORE2_MSB -: `CAM_CHANS]),
    .new_out    (core_new[2])
  );

  // Sequencer core 3 flags
  cam_core_flags #(
    .IMPL (CORE_IMPL[3])
  ) u_core3 (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .check_in   (sequencer_core_3_check_in),
    .chan_en_in (chan_en_reg[`CAM_CORE3_MSB -: `CAM_CHANS]),
    .clear_in   (flag_clear[`CAM_CORE3_MSB -: `CAM_CHANS]),
    .flags_out  (flags_all[`CAM_CORE3_MSB -: `CAM_CHANS]),
    .new_out    (core_new[3])
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Only one read is open at a time
  assign s_axi_arready_out = ~rvalid_reg;
  assign ar_take           = s_axi_arvalid_in & s_axi_arready_out;

  // Read decode
  assign rd_sel_flags    = s_axi_araddr_in[`CAM_ADDR_W-1:2] == OFS_FLAGS[`CAM_ADDR_W-1:2];
  assign rd_sel_chan_en  = s_axi_araddr_in[`CAM_ADDR_W-1:2] == OFS_CHAN_EN[`CAM_ADDR_W-1:2];
  assign rd_sel_irq_stat = s_axi_araddr_in[`CAM_ADDR_W-1:2] == OFS_IRQ_STATUS[`CAM_ADDR_W-1:2];
  assign rd_sel_irq_mask = s_axi_araddr_in[`CAM_ADDR_W-1:2] == OFS_IRQ_MASK[`CAM_ADDR_W-1:2];
  assign rd_hit          = rd_sel_flags | rd_sel_chan_en | rd_sel_irq_stat | rd_sel_irq_mask;

  // Read data select; the flag word is only sampled, never cleared here
  assign rd_word = rd_sel_flags    ? flags_all :
                   rd_sel_chan_en  ? chan_en_reg :
                   rd_sel_irq_stat ? {28'h000_0000, irq_stat_reg} :
                   rd_sel_irq_mask ? {28'h000_0000, irq_mask_reg} :
                   32'h0000_0000;

  // Read data register, held until rready
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `CAM_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `CAM_RESP_OKAY : `CAM_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;

  // ****************************************************************
  // Interrupt status and output
  // ****************************************************************
  // A read of the status word clears it; a new event in that cycle survives
  assign rd_clr_irq    = ar_take & rd_sel_irq_stat;
  assign irq_stat_next = core_new | (rd_clr_irq ? 4'h0 : irq_stat_reg);

  // Per-core sticky event bits
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_reg <= `CAM_IRQ_STAT_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

endmodule : cam_top

/* File: tb/cam_chk.sv */
// Bus timing and flag assertions for the check activity monitor
`timescale 1ns/1ps
`include "cam_defines.svh"
module cam_chk (
  input wire logic                   sys_clk_in,
  input wire logic                   rst_b_in,
  input wire cam_pkg::cam_chan_t     sequencer_core_0_check_in,
  input wire cam_pkg::cam_chan_t     sequencer_core_1_check_in,
  input wire cam_pkg::cam_chan_t     sequencer_core_2_check_in,
  input wire cam_pkg::cam_chan_t     sequencer_core_3_check_in,
  input wire logic                   s_axi_awvalid_in,
  input wire logic                   s_axi_awready_out,
  input wire logic [`CAM_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic                   s_axi_wvalid_in,
  input wire logic                   s_axi_wready_out,
  input wire cam_pkg::cam_word_t     s_axi_wdata_in,
  input wire logic                   s_axi_bvalid_out,
  input wire logic                   s_axi_bready_in,
  input wire cam_pkg::cam_resp_t     s_axi_bresp_out,
  input wire logic                   s_axi_arvalid_in,
  input wire logic                   s_axi_arready_out,
  input wire logic [`CAM_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic                   s_axi_rvalid_out,
  input wire logic                   s_axi_rready_in,
  input wire cam_pkg::cam_word_t     s_axi_rdata_out,
  input wire cam_pkg::cam_resp_t     s_axi_rresp_out,
  input wire logic                   irq_out
);
  cam_pkg::cam_word_t seen_reg, clr_reg, chk_w;
  // Handshakes and all checks in flag layout
  wire wr_go = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire rd_go = s_axi_arvalid_in && s_axi_arready_out;
  assign chk_w = {<<{sequencer_core_3_check_in, sequencer_core_2_check_in,
                     sequencer_core_1_check_in, sequencer_core_0_check_in}};
  // Superset of flags that may be set; a clear lands one cycle after the take
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seen_reg <= 32'h0;
      clr_reg  <= 32'h0;
    end else begin
      seen_reg <= (seen_reg & ~clr_reg) | chk_w;
      clr_reg  <= (wr_go && s_axi_awaddr_in == `CAM_OFS_FLAGS) ? s_axi_wdata_in : 32'h0;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_b_lat; wr_go |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response not two cycles after take");
  property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_lat; rd_go |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
  property p_rd_err; rd_go && s_axi_araddr_in > 8'h0F |=> s_axi_rresp_out == `CAM_RESP_SLVERR && s_axi_rdata_out == 32'h0; endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_wr_err; wr_go && s_axi_awaddr_in > 8'h0F |=> ##1 s_axi_bresp_out == `CAM_RESP_SLVERR; endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  property p_flag_sub; rd_go && s_axi_araddr_in == `CAM_OFS_FLAGS |=> (s_axi_rdata_out & ~seen_reg) == 32'h0; endproperty
  a_flag_sub: assert property (p_flag_sub) else $error("flag set without a check");
  property p_irq_rise; $rose(irq_out) |-> $past(chk_w != 32'h0) || $rose(s_axi_bvalid_out); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
  c_w1c: cover property (wr_go && s_axi_awaddr_in == `CAM_OFS_FLAGS);
  c_irq: cover property ($rose(irq_out));
  c_err: cover property (rd_go && s_axi_araddr_in > 8'h0F);
endmodule : cam_chk

bind cam_top cam_chk u_chk (.sys_clk_in, .rst_b_in, .sequencer_core_0_check_in, .sequencer_core_1_check_in,
  .sequencer_core_2_check_in, .sequencer_core_3_check_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out, .irq_out);

/* File: tb/cam_seq_model.sv */
// Sequencer cores reporting supervising checks as pulses or short levels
`timescale 1ns/1ps
module cam_seq_model (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               go_in,
  input  wire logic               slow_in,
  input  wire cam_pkg::cam_word_t pat_in,
  output cam_pkg::cam_chan_t      core0_out,
  output cam_pkg::cam_chan_t      core1_out,
  output cam_pkg::cam_chan_t      core2_out,
  output cam_pkg::cam_chan_t      core3_out
);
  logic [3:0]         sh_reg;
  logic               slow_reg;
  cam_pkg::cam_word_t pat_reg;
  cam_pkg::cam_word_t pat_rev;
  // Fast: one-cycle pulse; slow: two-cycle wait then two-cycle level
  wire act = slow_reg ? (sh_reg[2] | sh_reg[3]) : sh_reg[0];
  assign pat_rev = {<<{pat_reg}};
  assign {core3_out, core2_out, core1_out, core0_out} = act ? pat_rev : 32'h0;
  // Capture the pattern and walk the delay line
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sh_reg <= 4'h0;
    end else begin
      sh_reg <= {sh_reg[2:0], go_in};
      if (go_in) begin
        pat_reg  <= pat_in;
        slow_reg <= slow_in;
      end
    end
  end
endmodule : cam_seq_model

/* File: tb/testbench.sv */
// Self-checking bench for the check activity monitor
`timescale 1ns/1ps
`include "cam_defines.svh"
module testbench;
  logic               clk, rst_b, go, slow, awv, wv, arv, brdy, rrdy, awr, wr, bv, arr, rv, irq;
  logic [7:0]         awa, ara;
  logic [31:0]        rnd, p;
  cam_pkg::cam_word_t wd, rd, e_fl, e_en;
  cam_pkg::cam_resp_t br, rr;
  cam_pkg::cam_chan_t c0, c1, c2, c3;
  logic [3:0]         e_st, e_ms;
  int                 error_cnt, tests_run;
  cam_top u_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .sequencer_core_0_check_in(c0),
    .sequencer_core_1_check_in(c1), .sequencer_core_2_check_in(c2), .sequencer_core_3_check_in(c3),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrdy), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .irq_out(irq));
  cam_seq_model u_seq (.sys_clk_in(clk), .rst_b_in(rst_b), .go_in(go), .slow_in(slow), .pat_in(p),
    .core0_out(c0), .core1_out(c1), .core2_out(c2), .core3_out(c3));
  // Free-running bus clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  task automatic chk(input cam_pkg::cam_word_t g, input cam_pkg::cam_word_t e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // Bus write, then model update and response compare
  task automatic axi_wr(input logic [7:0] a, input cam_pkg::cam_word_t d);
    int n;
    n = 0;
    rnd = nxt(rnd);
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (n >= rnd[1:0] && !brdy) brdy <= 1'b1;
      n++;
    end while (!(bv === 1'b1 && brdy === 1'b1));
    brdy <= 1'b0;
    chk({30'h0, br}, {30'h0, (a > 8'h0F) ? `CAM_RESP_SLVERR : `CAM_RESP_OKAY});
    if (a == `CAM_OFS_FLAGS) e_fl = e_fl & ~d;
    if (a == `CAM_OFS_CHAN_EN) begin
      e_en = d;
      e_fl = e_fl & d;
    end
    if (a == `CAM_OFS_IRQ_MASK) e_ms = d[3:0];
  endtask : axi_wr
  // Bus read compared with the model; a status read clears it
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    rnd = nxt(rnd);
    @(posedge clk);
    arv <= 1'b1; ara <= a;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (n >= rnd[1:0] && !rrdy) rrdy <= 1'b1;
      n++;
    end while (!(rv === 1'b1 && rrdy === 1'b1));
    rrdy <= 1'b0;
    chk({30'h0, rr}, {30'h0, (a > 8'h0F) ? `CAM_RESP_SLVERR : `CAM_RESP_OKAY});
    chk(rd, a == 8'h00 ? e_fl : a == 8'h04 ? e_en : a == 8'h08 ? {28'h0, e_st} :
            a == 8'h0C ? {28'h0, e_ms} : 32'h0);
    if (a == `CAM_OFS_IRQ_STATUS) e_st = 4'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, |(e_st & e_ms)});
  endtask : axi_rd
  // Partner reports checks; model sets enabled flags and core status
  task automatic fire(input logic [31:0] pt, input logic s);
    @(posedge clk);
    p <= pt; slow <= s; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    for (int n = 0; n < 4; n++) if (((pt & e_en & ~e_fl) >> (24 - 8 * n)) & 32'hFF) e_st[n] = 1'b1;
    e_fl = e_fl | (pt & e_en);
    chk({31'h0, irq}, {31'h0, |(e_st & e_ms)});
  endtask : fire
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0; go = 1'b0; slow = 1'b0; awv = 1'b0; wv = 1'b0; arv = 1'b0; brdy = 1'b0; rrdy = 1'b0;
    awa = 8'h0; ara = 8'h0; wd = 32'h0; p = 32'h0; rnd = 32'h702BD6B7;
    e_fl = `CAM_FLAGS_RESET; e_en = `CAM_CHAN_EN_RESET; e_st = 4'h0; e_ms = 4'h0;
    error_cnt = 0; tests_run = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a += 4) axi_rd(a[7:0]);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      fire(32'h1 << (31 - i), i[0]);
      axi_rd(8'h00);
      axi_wr(8'h00, 32'h1 << (31 - i));
    end
    $display("test mapping done");
    repeat (20) begin
      rnd = nxt(rnd);
      fire(rnd, rnd[3]);
      axi_rd(8'h00);
      axi_rd(8'h00);
      rnd = nxt(rnd);
      axi_wr(8'h00, rnd);
      axi_rd(8'h00);
    end
    $display("test sticky done");
    axi_wr(8'h04, nxt(rnd) & 32'h5AA5F00F);
    fire(32'hFFFFFFFF, 1'b0);
    axi_rd(8'h00);
    axi_rd(8'h04);
    axi_wr(8'h04, 32'hFFFFFFFF);
    $display("test unused channels done");
    repeat (6) begin
      rnd = nxt(rnd);
      axi_wr(8'h0C, rnd);
      axi_wr(8'h08, 32'hFFFFFFFF);
      fire(rnd, rnd[9]);
      axi_rd(8'h0C);
      axi_rd(8'h08);
      axi_wr(8'h00, 32'hFFFFFFFF);
    end
    $display("test interrupt done");
    axi_rd(8'h10);
    axi_wr(8'h40, 32'hFFFFFFFF);
    axi_rd(8'h00);
    $display("test unmapped done");
    close_out();
  end
  // Cut a hang short
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule : testbench
